// file: psd_decoder.v
// pwm sequence decoder: wishbone registers, dma fetch, sequencing and pins
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "psd_defines.vh"
module psd_decoder #(
  parameter AW = 32                // dma address width
) (
  // clock, reset, enable
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  // wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // dma read master (half word reads)
  output reg           dma_req_o,
  output reg  [AW-1:0] dma_adr_o,
  input  wire          dma_ack_i,
  input  wire [15:0]   dma_dat_i,
  // pwm pins
  output reg  [3:0]    pwm_o,
  output reg  [3:0]    pwm_oe_o
);
  //////////////////////////////////////////////////////////////////////////
  // state codes
  localparam S_IDLE  = 3'h0;       // no generation
  localparam S_FETCH = 3'h1;       // dma reading one load
  localparam S_APPLY = 3'h2;       // apply at once if idle, else wait for period end
  localparam S_WAIT  = 3'h3;       // waiting for refresh or advance
  localparam S_DELAY = 3'h4;       // end delay periods
  localparam S_HOLD  = 3'h5;       // playback done, keep last values
  localparam S_STOP  = 3'h6;       // finishing period before stop

  // registers
  reg  [3:0]    ctrl_reg;          // load layout, advance mode, updown
  reg  [14:0]   top_reg;           // period top register
  reg  [15:0]   loop_reg;          // loop repeat count
  reg  [AW-1:0] ptr_reg [0:1];     // sequence base pointers
  reg  [14:0]   len_reg [0:1];     // sequence lengths
  reg  [23:0]   ref_reg [0:1];     // refresh counts
  reg  [23:0]   dly_reg [0:1];     // end delay periods
  reg  [3:0]    idle_reg;          // idle pin levels
  reg  [5:0]    evt_reg;           // sticky events
  // sequencing state
  reg  [2:0]    st_reg;
  reg           seq_reg;           // current sequence
  reg  [14:0]   idx_reg;           // half words consumed
  reg  [1:0]    sub_reg;           // word within one load
  reg  [63:0]   stage_reg;         // fetched load
  reg  [14:0]   stop_reg;          // fetched period top (wave)
  reg  [63:0]   word_reg;          // applied compare words
  reg  [14:0]   wtop_reg;          // applied wave top
  reg  [23:0]   per_reg;           // period counter
  reg  [15:0]   loops_reg;         // loops remaining
  reg           first_reg;         // next apply is first of sequence
  reg           run_reg;           // wave counter running
  reg           adv_reg;           // pending advance task
  reg           stopreq_reg;       // pending stop
  wire          period_end;
  wire [3:0]    wc_pwm;
  wire [1:0]    load;
  wire [2:0]    nwords;            // half words per load
  wire [14:0]   eff_top;
  wire          wb_go;
  reg  [3:0]    tasks;             // task strobes from bus write
  reg  [5:0]    evt_set;           // events raised this cycle
  integer       j;

  assign load    = ctrl_reg[`PSD_CTRL_LOAD_HI:`PSD_CTRL_LOAD_LO];
  assign nwords  = (load == `PSD_LOAD_COMMON) ? 3'h1 :
                   (load == `PSD_LOAD_GROUPED) ? 3'h2 : 3'h4;
  assign eff_top = (load == `PSD_LOAD_WAVE) ? wtop_reg : top_reg;
  assign wb_go   = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // route a load to the four channels
  function [63:0] route;
    input [1:0]  ld;
    input [63:0] s;
    begin
      case (ld)
        `PSD_LOAD_COMMON:  route = {4{s[15:0]}};
        `PSD_LOAD_GROUPED: route = {{2{s[31:16]}}, {2{s[15:0]}}};
        `PSD_LOAD_WAVE:    route = {16'h0000, s[47:0]};
        default:           route = s;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // wave counter
  psd_wave_counter u_wc (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .run_i        (run_reg),
    .updown_i     (ctrl_reg[`PSD_CTRL_UPDN_BIT]),
    .top_i        (eff_top),
    .word_i       (word_reg),
    .pwm_o        (wc_pwm),
    .period_end_o (period_end)
  );

  //////////////////////////////////////////////////////////////////////////
  // task strobes from a write to the task register
  always @* begin
    tasks = 4'h0;
    if (wb_go && wb_we_i && wb_adr_i == `PSD_TASK_OFS && wb_sel_i[0])
      tasks = wb_dat_i[3:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone register file, ack one cycle after request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= 4'h0;
      top_reg  <= `PSD_TOP_RST;
      loop_reg <= 16'h0000;
      idle_reg <= 4'h0;
      for (j = 0; j < 2; j = j + 1) begin
        ptr_reg[j] <= {AW{1'b0}};
        len_reg[j] <= 15'h0000;
        ref_reg[j] <= 24'h000000;
        dly_reg[j] <= 24'h000000;
      end
    end else if (ce_i) begin
      wb_ack_o <= wb_go;
      wb_dat_o <= 32'h0000_0000;
      if (wb_go && wb_we_i) begin
        case (wb_adr_i)
          `PSD_CTRL_OFS: ctrl_reg   <= wb_dat_i[3:0];
          `PSD_TOP_OFS:  top_reg    <= wb_dat_i[14:0];
          `PSD_LOOP_OFS: loop_reg   <= wb_dat_i[15:0];
          `PSD_PTR0_OFS: ptr_reg[0] <= wb_dat_i[AW-1:0];
          `PSD_LEN0_OFS: len_reg[0] <= wb_dat_i[14:0];
          `PSD_REF0_OFS: ref_reg[0] <= wb_dat_i[23:0];
          `PSD_DLY0_OFS: dly_reg[0] <= wb_dat_i[23:0];
          `PSD_PTR1_OFS: ptr_reg[1] <= wb_dat_i[AW-1:0];
          `PSD_LEN1_OFS: len_reg[1] <= wb_dat_i[14:0];
          `PSD_REF1_OFS: ref_reg[1] <= wb_dat_i[23:0];
          `PSD_DLY1_OFS: dly_reg[1] <= wb_dat_i[23:0];
          `PSD_IDLE_OFS: idle_reg   <= wb_dat_i[3:0];
          default: ;                                   // unmapped: ignored
        endcase
      end else if (wb_go) begin
        case (wb_adr_i)
          `PSD_CTRL_OFS: wb_dat_o <= {28'h0, ctrl_reg};
          `PSD_TOP_OFS:  wb_dat_o <= {17'h0, top_reg};
          `PSD_LOOP_OFS: wb_dat_o <= {16'h0, loop_reg};
          `PSD_PTR0_OFS: wb_dat_o <= ptr_reg[0];
          `PSD_LEN0_OFS: wb_dat_o <= {17'h0, len_reg[0]};
          `PSD_REF0_OFS: wb_dat_o <= {8'h0, ref_reg[0]};
          `PSD_DLY0_OFS: wb_dat_o <= {8'h0, dly_reg[0]};
          `PSD_PTR1_OFS: wb_dat_o <= ptr_reg[1];
          `PSD_LEN1_OFS: wb_dat_o <= {17'h0, len_reg[1]};
          `PSD_REF1_OFS: wb_dat_o <= {8'h0, ref_reg[1]};
          `PSD_DLY1_OFS: wb_dat_o <= {8'h0, dly_reg[1]};
          `PSD_EVT_OFS:  wb_dat_o <= {26'h0, evt_reg};
          `PSD_STAT_OFS: wb_dat_o <= {25'h0, run_reg, seq_reg, 2'h0, st_reg};
          `PSD_IDLE_OFS: wb_dat_o <= {28'h0, idle_reg};
          default:       wb_dat_o <= 32'h0000_0000;   // unmapped reads zero
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky events: write one to clear, a set in the same cycle wins
  always @(posedge clk_i) begin
    if (rst_i)
      evt_reg <= 6'h00;
    else if (ce_i) begin
      if (wb_go && wb_we_i && wb_adr_i == `PSD_EVT_OFS && wb_sel_i[0])
        evt_reg <= (evt_reg & ~wb_dat_i[5:0]) | evt_set;
      else
        evt_reg <= evt_reg | evt_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: fetch, apply on period end, pace, chain, stop
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= S_IDLE;
      seq_reg     <= 1'b0;
      idx_reg     <= 15'h0000;
      sub_reg     <= 2'h0;
      stage_reg   <= 64'h0;
      stop_reg    <= 15'h0000;
      word_reg    <= {4{`PSD_WORD_RST}};
      wtop_reg    <= 15'h0000;
      per_reg     <= 24'h000000;
      loops_reg   <= 16'h0000;
      first_reg   <= 1'b0;
      run_reg     <= 1'b0;
      adv_reg     <= 1'b0;
      stopreq_reg <= 1'b0;
      dma_req_o   <= 1'b0;
      dma_adr_o   <= {AW{1'b0}};
      evt_set     <= 6'h00;
      pwm_o       <= 4'h0;
      pwm_oe_o    <= 4'h0;
    end else if (ce_i) begin
      evt_set <= 6'h00;
      // pins: wave output while running, idle level otherwise
      pwm_o    <= run_reg ? wc_pwm : idle_reg;
      pwm_oe_o <= 4'hf;
      if (tasks[`PSD_TASK_ADV])
        adv_reg <= 1'b1;
      if (tasks[`PSD_TASK_STOP] && st_reg != S_IDLE)
        stopreq_reg <= 1'b1;
      if (tasks[`PSD_TASK_BEGIN0] || tasks[`PSD_TASK_BEGIN1]) begin
        // a begin task restarts from the base pointer
        seq_reg     <= tasks[`PSD_TASK_BEGIN1];
        idx_reg     <= 15'h0000;
        sub_reg     <= 2'h0;
        first_reg   <= 1'b1;
        loops_reg   <= loop_reg;
        stopreq_reg <= 1'b0;
        adv_reg     <= 1'b0;
        dma_req_o   <= 1'b1;
        dma_adr_o   <= ptr_reg[tasks[`PSD_TASK_BEGIN1]];
        st_reg      <= S_FETCH;
      end else begin
        case (st_reg)
          S_FETCH: begin
            if (dma_ack_i) begin
              stage_reg[16*sub_reg +: 16] <= dma_dat_i;
              if (load == `PSD_LOAD_WAVE && sub_reg == 2'h3)
                stop_reg <= dma_dat_i[14:0];
              idx_reg   <= idx_reg + 15'h0001;
              dma_adr_o <= dma_adr_o + {{(AW-2){1'b0}}, 2'h2};
              if (sub_reg + 2'h1 == nwords[1:0] || nwords == 3'h4 && sub_reg == 2'h3) begin
                dma_req_o <= 1'b0;
                sub_reg   <= 2'h0;
                st_reg    <= S_APPLY;
              end else
                sub_reg <= sub_reg + 2'h1;
            end
          end
          S_APPLY: begin
            // idle counter starts at once; a running one swaps at period end
            if (!run_reg || period_end) begin
              word_reg <= route(load, stage_reg);
              wtop_reg <= stop_reg;
              run_reg  <= 1'b1;
              per_reg  <= 24'h000000;
              if (first_reg)
                evt_set[seq_reg] <= 1'b1;
              first_reg <= 1'b0;
              adv_reg   <= 1'b0;
              if (idx_reg >= len_reg[seq_reg])
                evt_set[`PSD_EVT_FIN0 + seq_reg] <= 1'b1;
              st_reg <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (stopreq_reg) st_reg <= S_STOP;
            else if (ctrl_reg[`PSD_CTRL_ADV_BIT] ? adv_reg :
                     (per_reg >= ref_reg[seq_reg])) begin  // fetch lands next end
              adv_reg <= 1'b0;
              if (idx_reg < len_reg[seq_reg]) begin
                dma_req_o <= 1'b1;
                st_reg    <= S_FETCH;
              end else if (ctrl_reg[`PSD_CTRL_ADV_BIT] || dly_reg[seq_reg] == 24'h0)
                st_reg <= S_DELAY;
              else begin
                per_reg <= 24'h000001;
                st_reg  <= S_DELAY;
              end
            end else if (period_end)
              per_reg <= per_reg + 24'h000001;
          end
          S_DELAY: begin
            if (stopreq_reg) st_reg <= S_STOP;
            else if (!ctrl_reg[`PSD_CTRL_ADV_BIT] && per_reg != 24'h0 &&
                     per_reg <= dly_reg[seq_reg]) begin
              if (period_end) per_reg <= per_reg + 24'h000001;
            end else if (loops_reg == 16'h0000 ||
                         (seq_reg && loops_reg == 16'h0001)) begin
              if (loops_reg != 16'h0000)
                evt_set[`PSD_EVT_LOOPSDONE] <= 1'b1;
              st_reg <= S_HOLD;
            end else begin
              if (seq_reg) loops_reg <= loops_reg - 16'h0001;
              seq_reg   <= ~seq_reg;
              idx_reg   <= 15'h0000;
              first_reg <= 1'b1;
              dma_adr_o <= ptr_reg[~seq_reg];
              dma_req_o <= 1'b1;
              st_reg    <= S_FETCH;
            end
          end
          S_HOLD: begin
            if (stopreq_reg) st_reg <= S_STOP;
          end
          S_STOP: begin
            if (period_end || !run_reg) begin
              run_reg     <= 1'b0;
              stopreq_reg <= 1'b0;
              dma_req_o   <= 1'b0;
              evt_set[`PSD_EVT_STOPPED] <= 1'b1;
              st_reg      <= S_IDLE;
            end
          end
          S_IDLE: ;
          default: st_reg <= S_IDLE;
        endcase
        // a stop during fetch or apply also ends after the period
        if (stopreq_reg && (st_reg == S_FETCH || st_reg == S_APPLY) && !dma_req_o)
          st_reg <= S_STOP;
      end
    end
  end
endmodule
`default_nettype wire

// file: psd_defines.vh
// constants for the pwm sequence decoder: register map, field positions, reset values
`ifndef PSD_DEFINES_VH
`define PSD_DEFINES_VH

// register byte offsets on the wishbone slave
`define PSD_CTRL_OFS      8'h00
`define PSD_TOP_OFS       8'h04
`define PSD_LOOP_OFS      8'h08
`define PSD_PTR0_OFS      8'h0c
`define PSD_LEN0_OFS      8'h10
`define PSD_REF0_OFS      8'h14
`define PSD_DLY0_OFS      8'h18
`define PSD_PTR1_OFS      8'h1c
`define PSD_LEN1_OFS      8'h20
`define PSD_REF1_OFS      8'h24
`define PSD_DLY1_OFS      8'h28
`define PSD_TASK_OFS      8'h2c
`define PSD_EVT_OFS       8'h30
`define PSD_STAT_OFS      8'h34
`define PSD_IDLE_OFS      8'h38

// ctrl field positions
`define PSD_CTRL_LOAD_LO  0
`define PSD_CTRL_LOAD_HI  1
`define PSD_CTRL_ADV_BIT  2
`define PSD_CTRL_UPDN_BIT 3

// task bits
`define PSD_TASK_BEGIN0   0
`define PSD_TASK_BEGIN1   1
`define PSD_TASK_ADV      2
`define PSD_TASK_STOP     3

// event bits
`define PSD_EVT_BEGUN0    0
`define PSD_EVT_BEGUN1    1
`define PSD_EVT_FIN0      2
`define PSD_EVT_FIN1      3
`define PSD_EVT_STOPPED   4
`define PSD_EVT_LOOPSDONE 5

// load layouts
`define PSD_LOAD_COMMON   2'h0
`define PSD_LOAD_GROUPED  2'h1
`define PSD_LOAD_SINGLE   2'h2
`define PSD_LOAD_WAVE     2'h3

// reset values
`define PSD_TOP_RST       15'h03e8
`define PSD_WORD_RST      16'h0000

`endif

// file: psd_wave_counter.v
// shared 15-bit wave counter with four compare channels
`timescale 1ns/1ns
`default_nettype none
module psd_wave_counter (
  // clock and control
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        run_i,      // counter runs while high
  input  wire        updown_i,   // 1: up and down (center aligned)
  input  wire [14:0] top_i,      // period top value
  input  wire [63:0] word_i,     // four {pol,cmp} half words
  // results
  output reg  [3:0]  pwm_o,
  output reg         period_end_o // one cycle pulse at end of period
);
  reg  [14:0] cnt_reg;           // shared counter
  reg         down_reg;          // counting down in up/down mode
  wire        at_end;            // last step of the period
  integer     k;

  assign at_end = updown_i ? (down_reg && cnt_reg <= 15'h0001) : (cnt_reg + 15'h0001 >= top_i);

  //////////////////////////////////////////////////////////////////////////
  // one counter for all channels, single period for all four
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg      <= 15'h0000;
      down_reg     <= 1'b0;
      period_end_o <= 1'b0;
      pwm_o        <= 4'h0;
    end else if (ce_i) begin
      period_end_o <= run_i && at_end;
      if (!run_i) begin
        cnt_reg  <= 15'h0000;
        down_reg <= 1'b0;
      end else if (at_end) begin
        cnt_reg  <= 15'h0000;
        down_reg <= 1'b0;
      end else if (updown_i && !down_reg && cnt_reg + 15'h0001 >= top_i) begin
        cnt_reg  <= top_i;
        down_reg <= 1'b1;
      end else if (down_reg) begin
        cnt_reg  <= cnt_reg - 15'h0001;
      end else begin
        cnt_reg  <= cnt_reg + 15'h0001;
      end
      // output high below compare before polarity, polarity 0 flips first edge
      for (k = 0; k < 4; k = k + 1) begin
        pwm_o[k] <= (cnt_reg < word_i[16*k +: 15]) ^ ~word_i[16*k+15];
      end
    end
  end
endmodule
`default_nettype wire

// file: psd_decoder_monitor.sv
// assertion checker for the decoder's bus, dma and pin ports
`timescale 1ns/1ns
`default_nettype none
`include "psd_defines.vh"
module psd_decoder_monitor #(
  parameter AW = 32                 // dma address width
) (
  // clock, reset, enable
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  // wishbone slave
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // dma read master
  input wire logic          dma_req_o,
  input wire logic [AW-1:0] dma_adr_o,
  input wire logic          dma_ack_i,
  input wire logic [15:0]   dma_dat_i,
  // pwm pins
  input wire logic [3:0]    pwm_o,
  input wire logic [3:0]    pwm_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h3c)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////////////////////////
  // dma fetch
  a_fetch_step: assert property (dma_req_o && dma_ack_i ##1 dma_req_o |->
    dma_adr_o == $past(dma_adr_o) + 2) else $error("fetch address did not step by two");
  a_fetch_hold: assert property (dma_req_o && !dma_ack_i |=>
    dma_req_o && $stable(dma_adr_o)) else $error("fetch request dropped or moved");
  a_begin_fetch: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h2c
    && wb_dat_i[0] && wb_sel_i[0]) |-> ##[0:4] dma_req_o) else $error("begin without fetch");
  ////////////////////////////////////////////////////////////////////////////////
  // pin enables, and outputs frozen while clock enable is low
  a_oe_release: assert property ($past(rst_i) |=> pwm_oe_o == 4'hf)
    else $error("pin enables not set after reset");
  a_oe_keep: assert property (pwm_oe_o == 4'hf |=> pwm_oe_o == 4'hf)
    else $error("pin enables dropped");
  a_ce_freeze: assert property (!ce_i |=> $stable(pwm_o) && $stable(wb_ack_o)
    && $stable(dma_req_o)) else $error("outputs moved while clock enable low");
  // main scenarios seen
  c_fetch: cover property (dma_req_o && dma_ack_i);
  c_stop: cover property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h2c && wb_dat_i[3]));
  c_unmapped: cover property (wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h3c));
endmodule
bind psd_decoder psd_decoder_monitor #(.AW(AW)) i_psd_decoder_monitor (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dma_req_o(dma_req_o), .dma_adr_o(dma_adr_o), .dma_ack_i(dma_ack_i),
  .dma_dat_i(dma_dat_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
`default_nettype wire

// file: psd_ram_model.sv
// system ram model answering the decoder's half word reads
`timescale 1ns/1ns
`default_nettype none
module psd_ram_model (
  // clock and wait states
  input  wire logic        clk_i,
  input  wire logic [1:0]  lat_i,
  // dma read port
  input  wire logic        dma_req_i,
  input  wire logic [31:0] dma_adr_i,
  output var  logic        dma_ack_o,
  output var  logic [15:0] dma_dat_o
);
  logic [15:0] mem [0:255];  // half words, loaded by the bench
  logic [1:0]  wait_reg;     // wait cycles spent on this read
  initial begin
    dma_ack_o = 1'b0;
    dma_dat_o = 16'h0000;
    wait_reg = 2'h0;
  end
  // one ack pulse per half word after lat_i wait cycles
  always @(posedge clk_i) begin
    dma_ack_o <= 1'b0;
    dma_dat_o <= ~dma_dat_o;  // data not valid outside ack, keep it moving
    if (dma_req_i && !dma_ack_o) begin
      if (wait_reg >= lat_i) begin
        dma_ack_o <= 1'b1;
        dma_dat_o <= mem[dma_adr_i[8:1]];  // only ram is ever addressed
        wait_reg <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: pwm_sequence_decoder_dma_tb_top.sv
// self-checking bench for the pwm sequence decoder
`timescale 1ns/1ns
`default_nettype none
`include "psd_defines.vh"
module pwm_sequence_decoder_dma_tb_top;
  localparam int TOP = 20;  // short period top for the runs
  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, pwm_o, pwm_oe_o;
  logic [31:0] wb_dat_i, wb_dat_o, dma_adr_o, rd;
  logic        dma_req_o, dma_ack_i;
  logic [15:0] dma_dat_i;
  logic [15:0] w [0:3];     // words of the current sequence
  logic [1:0]  lat;         // ram wait states
  int          mismatches = 0, num_checks = 0, cyc_n = 0, mark, i;
  int          ack_t[$];    // fetch times
  logic [31:0] ack_a[$];    // fetch addresses
  psd_decoder #(.AW(32)) i_psd_decoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dma_req_o(dma_req_o), .dma_adr_o(dma_adr_o), .dma_ack_i(dma_ack_i),
    .dma_dat_i(dma_dat_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
  psd_ram_model i_psd_ram_model (.clk_i(clk_i), .lat_i(lat), .dma_req_i(dma_req_o),
    .dma_adr_i(dma_adr_o), .dma_ack_o(dma_ack_i), .dma_dat_o(dma_dat_i));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and fetch log
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (dma_req_o && dma_ack_i) begin
      ack_t.push_back(cyc_n);
      ack_a.push_back(dma_adr_o);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) check(1'b0, 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // random word with compare inside the period
  function automatic logic [15:0] rw();
    return {1'($urandom % 2), 15'(1 + $urandom % (TOP - 1))};
  endfunction
  // expected high cycles per period: polarity 0 starts low and rises at compare
  function automatic int hi(input logic [15:0] v, input int p);
    return v[15] ? int'(v[14:0]) : p - int'(v[14:0]);
  endfunction
  task automatic load(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      w[k] = rw();
      i_psd_ram_model.mem[idx + k] = w[k];
    end
  endtask
  task automatic duty(input int ch, input int p, input int exp);
    int h;
    h = 0;
    repeat (p) begin
      @(posedge clk_i);
      h += int'(pwm_o[ch] === 1'b1);
    end
    check(h, exp);
  endtask
  // stop, clear events, program sequence 0 and begin it
  task automatic run(input logic [3:0] ctl, input int ptr, input int len, input int rf,
                     input int loops);
    lat <= 2'($urandom % 4);
    wb(1, `PSD_TASK_OFS, 32'h8);
    repeat (3 * TOP) @(posedge clk_i);
    wb(1, `PSD_EVT_OFS, 32'h3f);
    wb(1, `PSD_CTRL_OFS, {28'h0, ctl});
    wb(1, `PSD_LOOP_OFS, 32'(loops));
    wb(1, `PSD_PTR0_OFS, 32'(ptr));
    wb(1, `PSD_LEN0_OFS, 32'(len));
    wb(1, `PSD_REF0_OFS, 32'(rf));
    wb(1, `PSD_DLY0_OFS, 32'h0);
    mark = ack_a.size();
    wb(1, `PSD_TASK_OFS, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #100000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
    {wb_adr_i, wb_sel_i, wb_dat_i, lat} = '0;
    wb_sel_i = 4'hf;
    void'($urandom(96));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `PSD_TOP_OFS, 32'h0);
    check(rd, 32'h3e8);
    wb(0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    wb(1, `PSD_TOP_OFS, 32'(TOP));
    $display("test registers done");
    load(0, 1);
    run(4'h0, 0, 1, 0, 0);
    repeat (6 * TOP) @(posedge clk_i);
    check(ack_a.size() - mark, 1);
    check(ack_a[mark], 0);
    for (i = 0; i < 4; i++) duty(i, TOP, hi(w[0], TOP));
    ce_i <= 1'b0;
    @(posedge clk_i);
    rd = pwm_o;
    repeat (7) @(posedge clk_i);
    check(pwm_o, rd);  // clock enable low freezes the pins
    ce_i <= 1'b1;
    wb(0, `PSD_EVT_OFS, 32'h0);
    check(rd & 32'h5, 32'h5);
    wb(1, `PSD_IDLE_OFS, 32'ha);
    wb(1, `PSD_TASK_OFS, 32'h8);
    repeat (2 * TOP) @(posedge clk_i);
    check(pwm_o, 4'ha);
    wb(0, `PSD_EVT_OFS, 32'h0);
    check(rd[4], 1'b1);
    $display("test common and stop done");
    load(8, 2);
    run(4'h1, 16, 2, 0, 0);
    repeat (4 * TOP) @(posedge clk_i);
    check(ack_a[mark], 16);
    for (i = 0; i < 4; i++) duty(i, TOP, hi(w[i / 2], TOP));
    load(16, 4);
    run(4'h2, 32, 4, 0, 0);
    repeat (4 * TOP) @(posedge clk_i);
    for (i = 0; i < 4; i++) duty(i, TOP, hi(w[i], TOP));
    $display("test grouped and single done");
    load(24, 3);
    w[3] = 16'(TOP + 12);
    i_psd_ram_model.mem[27] = w[3];
    run(4'h3, 48, 4, 0, 0);
    repeat (5 * (TOP + 12)) @(posedge clk_i);
    check(ack_a.size() - mark, 4);
    for (i = 0; i < 3; i++) duty(i, TOP + 12, hi(w[i], TOP + 12));
    $display("test wave done");
    load(32, 4);
    run(4'h0, 64, 4, 1, 0);
    repeat (12 * TOP) @(posedge clk_i);
    check(ack_a.size() - mark, 4);
    check(ack_t[mark + 3] - ack_t[mark + 2], 2 * TOP);
    duty(0, TOP, hi(w[3], TOP));
    $display("test refresh done");
    load(48, 3);
    run(4'h4, 96, 3, 0, 0);
    repeat (5 * TOP) @(posedge clk_i);
    duty(0, TOP, hi(w[0], TOP));
    for (i = 1; i < 3; i++) begin
      wb(1, `PSD_TASK_OFS, 32'h4);
      repeat (3 * TOP) @(posedge clk_i);
      duty(0, TOP, hi(w[i], TOP));
    end
    $display("test advance done");
    load(80, 1);
    i_psd_ram_model.mem[64] = rw();
    wb(1, `PSD_PTR1_OFS, 32'd160);
    wb(1, `PSD_LEN1_OFS, 32'h1);
    wb(1, `PSD_REF1_OFS, 32'h0);
    wb(1, `PSD_DLY1_OFS, 32'h0);
    run(4'h0, 128, 1, 0, 1);
    repeat (8 * TOP) @(posedge clk_i);
    check(ack_a.size() - mark, 2);
    check(ack_a[mark + 1], 160);
    duty(0, TOP, hi(w[0], TOP));
    wb(0, `PSD_EVT_OFS, 32'h0);
    check(rd & 32'h28, 32'h28);
    $display("test loop done");
    results();
  end
endmodule
`default_nettype wire
